// ==== rtl/and_exec.sv ====
// Decodes one instruction word and forms the result and condition field.
module and_exec
    import and_unit_pkg::*;
(
    input wire logic [DATA_W-1:0] instr,
    input wire logic [DATA_W-1:0] src_val,
    input wire logic [DATA_W-1:0] sec_val,
    input wire logic so_in,
    output op_kind_t kind,
    output logic [IDX_W-1:0] src_idx,
    output logic [IDX_W-1:0] sec_idx,
    output logic [IDX_W-1:0] tgt_idx,
    output logic [DATA_W-1:0] result,
    output logic cr_wr,
    output logic [CR_W-1:0] cr_val
);
    logic [5:0] prim;
    logic [9:0] xo;
    logic [HALF_W-1:0] imm;
    logic rec;
    logic is_neg;
    logic is_zero;

    assign prim = instr[PRIM_HI:PRIM_LO];
    assign src_idx = instr[SRC_HI:SRC_LO];
    assign tgt_idx = instr[TGT_HI:TGT_LO];
    assign sec_idx = instr[SEC_HI:SEC_LO];
    assign imm = instr[IMM_HI:IMM_LO];
    assign xo = instr[XO_HI:XO_LO];
    assign rec = instr[REC_POS];

    always_comb begin
        kind = OPK_NONE;
        result = WORD_ZERO;
        cr_wr = 1'b0;
        case (prim)
            OP_EXTENDED: begin
                if (xo == XO_AND) begin
                    kind = OPK_AND;
                    result = src_val & sec_val;
                    cr_wr = rec;
                end else if (xo == XO_ANDC) begin
                    kind = OPK_ANDC;
                    result = src_val & ~sec_val;
                    cr_wr = rec;
                end
            end
            OP_ANDI_LO: begin
                kind = OPK_ANDI_LO;
                result = src_val & {HALF_ZERO, imm};
                cr_wr = 1'b1;
            end
            OP_ANDI_HI: begin
                kind = OPK_ANDI_HI;
                result = src_val & {imm, HALF_ZERO};
                cr_wr = 1'b1;
            end
            default: begin
                kind = OPK_NONE;
            end
        endcase
    end

    assign is_neg = result[DATA_W-1];
    assign is_zero = (result == WORD_ZERO);
    always_comb begin
        cr_val = CR_RESET;
        cr_val[CR_NEG] = is_neg;
        cr_val[CR_POS] = !is_neg && !is_zero;
        cr_val[CR_ZERO] = is_zero;
        cr_val[CR_SO] = so_in;
    end
endmodule

// ==== rtl/and_unit_pkg.sv ====
// How it works
// - AND-with-complement writes source AND NOT second into the target register.
// - Record bit set updates condition field 0; clear leaves it untouched.
// - AND-with-complement never changes the fixed-point exception register.
// - Low immediate AND masks source with zero-extended 16-bit immediate.
// - High immediate AND masks source with immediate placed in upper half.
// - Immediate forms take source, target and immediate from fixed bit fields.
// - Low immediate AND always records, copies summary overflow, sets one flag.
// - High immediate AND always records flags and summary overflow copy.
// - Immediate ANDs always record and never touch the exception register.
// - Register AND writes source AND second, record bit gates flag update.
package and_unit_pkg;
    localparam int DATA_W = 32;
    localparam int ADDR_W = 8;
    localparam int STRB_W = 4;
    localparam int BYTE_W = 8;
    localparam int GPR_CNT = 32;
    localparam int IDX_W = 5;
    localparam int CR_W = 4;
    localparam int CNT_W = 8;
    localparam int HALF_W = 16;

    // Instruction fields, bit 0 of the word is the least significant bit here.
    localparam int PRIM_HI = 31;
    localparam int PRIM_LO = 26;
    localparam int SRC_HI = 25;
    localparam int SRC_LO = 21;
    localparam int TGT_HI = 20;
    localparam int TGT_LO = 16;
    localparam int SEC_HI = 15;
    localparam int SEC_LO = 11;
    localparam int XO_HI = 10;
    localparam int XO_LO = 1;
    localparam int REC_POS = 0;
    localparam int IMM_HI = 15;
    localparam int IMM_LO = 0;

    localparam logic [5:0] OP_EXTENDED = 6'h1F;
    localparam logic [5:0] OP_ANDI_LO = 6'h1C;
    localparam logic [5:0] OP_ANDI_HI = 6'h1D;
    localparam logic [9:0] XO_AND = 10'h01C;
    localparam logic [9:0] XO_ANDC = 10'h03C;
    localparam logic [HALF_W-1:0] HALF_ZERO = 16'h0000;

    // Condition field 0 layout and summary overflow position.
    localparam int CR_NEG = 3;
    localparam int CR_POS = 2;
    localparam int CR_ZERO = 1;
    localparam int CR_SO = 0;
    localparam int XER_SO_POS = 31;
    localparam int STAT_ILL_POS = 0;
    localparam int STAT_CNT_LO = 8;

    localparam logic [ADDR_W-1:0] OFF_INSTR = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_CR = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_XER = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h0C;
    localparam int GPR_SEL_POS = 7;
    localparam int GPR_IDX_HI = 6;
    localparam int GPR_IDX_LO = 2;
    localparam int WORD_LO = 2;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [DATA_W-1:0] WORD_ZERO = 32'h00000000;
    localparam logic [CR_W-1:0] CR_RESET = 4'h0;

    typedef enum logic [2:0] {
        OPK_NONE,
        OPK_AND,
        OPK_ANDC,
        OPK_ANDI_LO,
        OPK_ANDI_HI
    } op_kind_t;
endpackage

// ==== rtl/logical_and_unit.sv ====
// Logical AND datapath with its register file, condition field and an
// AXI4-Lite slave through which software loads operands and issues words.
module logical_and_unit
    import and_unit_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [DATA_W-1:0] s_axi_wdata,
    input wire logic [STRB_W-1:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic negative_flag,
    output logic positive_flag,
    output logic zero_flag,
    output logic so_copy
);
    logic aw_full_q, aw_full_d;
    logic [ADDR_W-1:0] aw_addr_q, aw_addr_d;
    logic w_full_q, w_full_d;
    logic [DATA_W-1:0] w_data_q, w_data_d;
    logic [STRB_W-1:0] w_strb_q, w_strb_d;
    logic bvalid_q, bvalid_d;
    logic [1:0] bresp_q, bresp_d;
    logic rvalid_q, rvalid_d;
    logic [DATA_W-1:0] rdata_q, rdata_d;
    logic [1:0] rresp_q, rresp_d;

    logic [DATA_W-1:0] gpr_q [GPR_CNT];
    logic [DATA_W-1:0] gpr_d [GPR_CNT];
    logic [DATA_W-1:0] instr_q, instr_d;
    logic [CR_W-1:0] cr_q, cr_d;
    logic [DATA_W-1:0] xer_q, xer_d;
    logic illegal_q, illegal_d;
    logic [CNT_W-1:0] count_q, count_d;

    logic do_write;
    logic [DATA_W-1:0] exec_word;
    op_kind_t exec_kind;
    logic [IDX_W-1:0] src_idx;
    logic [IDX_W-1:0] sec_idx;
    logic [IDX_W-1:0] tgt_idx;
    logic [DATA_W-1:0] exec_result;
    logic exec_cr_wr;
    logic [CR_W-1:0] exec_cr_val;

    function automatic logic [DATA_W-1:0] lane_merge(
        input logic [DATA_W-1:0] old_val,
        input logic [DATA_W-1:0] new_val,
        input logic [STRB_W-1:0] strb
    );
        logic [DATA_W-1:0] m;
        m = old_val;
        for (int i = 0; i < STRB_W; i++) begin
            if (strb[i]) begin
                m[i*BYTE_W +: BYTE_W] = new_val[i*BYTE_W +: BYTE_W];
            end
        end
        return m;
    endfunction

    // A write and its data may arrive in either order; each is held once taken.
    assign s_axi_awready = !aw_full_q;
    assign s_axi_wready = !w_full_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign negative_flag = cr_q[CR_NEG];
    assign positive_flag = cr_q[CR_POS];
    assign zero_flag = cr_q[CR_ZERO];
    assign so_copy = cr_q[CR_SO];

    assign do_write = aw_full_q && w_full_q && !bvalid_q;
    // The word issued is the held instruction with the new bytes laid over it.
    assign exec_word = lane_merge(instr_q, w_data_q, w_strb_q);

    and_exec u_exec (
        .instr(exec_word),
        .src_val(gpr_q[src_idx]),
        .sec_val(gpr_q[sec_idx]),
        .so_in(xer_q[XER_SO_POS]),
        .kind(exec_kind),
        .src_idx(src_idx),
        .sec_idx(sec_idx),
        .tgt_idx(tgt_idx),
        .result(exec_result),
        .cr_wr(exec_cr_wr),
        .cr_val(exec_cr_val)
    );

    // Write channel and instruction execution.
    always_comb begin
        aw_full_d = aw_full_q;
        aw_addr_d = aw_addr_q;
        w_full_d = w_full_q;
        w_data_d = w_data_q;
        w_strb_d = w_strb_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        gpr_d = gpr_q;
        instr_d = instr_q;
        cr_d = cr_q;
        xer_d = xer_q;
        illegal_d = illegal_q;
        count_d = count_q;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_full_d = 1'b1;
            aw_addr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_full_d = 1'b1;
            w_data_d = s_axi_wdata;
            w_strb_d = s_axi_wstrb;
        end
        if (bvalid_q && s_axi_bready) begin
            bvalid_d = 1'b0;
        end
        if (do_write) begin
            aw_full_d = 1'b0;
            w_full_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = RESP_OKAY;
            if (aw_addr_q[GPR_SEL_POS]) begin
                gpr_d[aw_addr_q[GPR_IDX_HI:GPR_IDX_LO]] =
                    lane_merge(gpr_q[aw_addr_q[GPR_IDX_HI:GPR_IDX_LO]], w_data_q, w_strb_q);
            end else if (aw_addr_q[GPR_SEL_POS-1:WORD_LO] == OFF_INSTR[GPR_SEL_POS-1:WORD_LO]) begin
                instr_d = exec_word;
                count_d = count_q + 1'b1;
                if (exec_kind == OPK_NONE) begin
                    illegal_d = 1'b1;
                end else begin
                    illegal_d = 1'b0;
                    gpr_d[tgt_idx] = exec_result;
                    if (exec_cr_wr) begin
                        cr_d = exec_cr_val;
                    end
                end
                xer_d = xer_q;
            end else if (aw_addr_q[GPR_SEL_POS-1:WORD_LO] == OFF_CR[GPR_SEL_POS-1:WORD_LO]) begin
                if (w_strb_q[0]) begin
                    cr_d = w_data_q[CR_W-1:0];
                end
            end else if (aw_addr_q[GPR_SEL_POS-1:WORD_LO] == OFF_XER[GPR_SEL_POS-1:WORD_LO]) begin
                xer_d = lane_merge(xer_q, w_data_q, w_strb_q);
            end else if (aw_addr_q[GPR_SEL_POS-1:WORD_LO] == OFF_STATUS[GPR_SEL_POS-1:WORD_LO]) begin
                bresp_d = RESP_OKAY;
            end else begin
                bresp_d = RESP_SLVERR;
            end
        end
    end

    // Read channel.
    always_comb begin
        rvalid_d = rvalid_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        if (rvalid_q && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_d = 1'b1;
            rresp_d = RESP_OKAY;
            rdata_d = WORD_ZERO;
            if (s_axi_araddr[GPR_SEL_POS]) begin
                rdata_d = gpr_q[s_axi_araddr[GPR_IDX_HI:GPR_IDX_LO]];
            end else if (s_axi_araddr[GPR_SEL_POS-1:WORD_LO] == OFF_INSTR[GPR_SEL_POS-1:WORD_LO]) begin
                rdata_d = instr_q;
            end else if (s_axi_araddr[GPR_SEL_POS-1:WORD_LO] == OFF_CR[GPR_SEL_POS-1:WORD_LO]) begin
                rdata_d[CR_W-1:0] = cr_q;
            end else if (s_axi_araddr[GPR_SEL_POS-1:WORD_LO] == OFF_XER[GPR_SEL_POS-1:WORD_LO]) begin
                rdata_d = xer_q;
            end else if (s_axi_araddr[GPR_SEL_POS-1:WORD_LO] == OFF_STATUS[GPR_SEL_POS-1:WORD_LO]) begin
                rdata_d[STAT_ILL_POS] = illegal_q;
                rdata_d[STAT_CNT_LO +: CNT_W] = count_q;
            end else begin
                rresp_d = RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            aw_full_q <= 1'b0;
            aw_addr_q <= '0;
            w_full_q <= 1'b0;
            w_data_q <= WORD_ZERO;
            w_strb_q <= '0;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
            rvalid_q <= 1'b0;
            rdata_q <= WORD_ZERO;
            rresp_q <= RESP_OKAY;
            instr_q <= WORD_ZERO;
            cr_q <= CR_RESET;
            xer_q <= WORD_ZERO;
            illegal_q <= 1'b0;
            count_q <= '0;
            for (int i = 0; i < GPR_CNT; i++) begin
                gpr_q[i] <= WORD_ZERO;
            end
        end else begin
            aw_full_q <= aw_full_d;
            aw_addr_q <= aw_addr_d;
            w_full_q <= w_full_d;
            w_data_q <= w_data_d;
            w_strb_q <= w_strb_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
            instr_q <= instr_d;
            cr_q <= cr_d;
            xer_q <= xer_d;
            illegal_q <= illegal_d;
            count_q <= count_d;
            gpr_q <= gpr_d;
        end
    end
endmodule

// ==== tb/and_unit_props.sv ====
module and_unit_props
    import and_unit_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [DATA_W-1:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic negative_flag,
    input wire logic positive_flag,
    input wire logic zero_flag,
    input wire logic so_copy
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    a_read_lat: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_write_lat: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write answer timing");
    a_aw_held: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
        else $error("address taken twice");
    a_err_zero: assert property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == WORD_ZERO)
        else $error("error read data not zero");
    a_flag_onehot:
    assert property (negative_flag || positive_flag || zero_flag |-> $onehot({negative_flag, positive_flag, zero_flag}))
        else $error("more than one flag set");
    a_flag_quiet:
    assert property (!$stable({negative_flag, positive_flag, zero_flag, so_copy}) |-> $rose(s_axi_bvalid))
        else $error("flags moved without a write");
endmodule

bind logical_and_unit and_unit_props and_unit_props_i (.*);

// ==== tb/axi_host.sv ====
module axi_host
    import and_unit_pkg::*;
(
    input wire logic sys_clk,
    output logic [ADDR_W-1:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [DATA_W-1:0] s_axi_wdata,
    output logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready,
    output logic [ADDR_W-1:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [DATA_W-1:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        s_axi_awaddr = 8'h00;
        s_axi_araddr = 8'h00;
        s_axi_wdata = 32'h00000000;
    end
    // Released payloads are inverted so a stale value is never mistaken for a held one.
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, output logic [1:0] r);
        @(posedge sys_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awvalid <= 1'b0;
                s_axi_awaddr <= ~a;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wvalid <= 1'b0;
                s_axi_wdata <= ~d;
            end
        end while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d, output logic [1:0] r);
        @(posedge sys_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arvalid <= 1'b0;
                s_axi_araddr <= ~a;
            end
        end while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
endmodule

// ==== tb/tb_top.sv ====
module tb_top;
    import and_unit_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk, reset;
    logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata, rv, xer;
    logic [STRB_W-1:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rr;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic negative_flag, positive_flag, zero_flag, so_copy;
    logic [CR_W-1:0] cr;
    logic [DATA_W-1:0] gm [GPR_CNT];
    int err_total, n_checks, cyc;
    logical_and_unit logical_and_unit_i (.*);
    axi_host axi_host_i (.*);
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    task automatic end_sim();
        if (err_total == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            err_total++;
            $display("[FAIL] %0t timeout", $time);
            end_sim();
        end
    end
    task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp, input string m);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic rchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic [1:0] r);
        axi_host_i.rd(a, rv, rr);
        chk(rv, d, "read data");
        chk({30'h0, rr}, {30'h0, r}, "read resp");
    endtask
    task automatic wgpr(input logic [4:0] n, input logic [DATA_W-1:0] d);
        axi_host_i.wr({1'b1, n, 2'b00}, d, rr);
        gm[n] = d;
        chk({30'h0, rr}, {30'h0, RESP_OKAY}, "write resp");
    endtask
    // Issues one word and predicts target, flags and exception register.
    task automatic op(input logic [DATA_W-1:0] ins);
        logic [DATA_W-1:0] a, r;
        logic upd;
        a = gm[ins[25:21]];
        upd = 1'b1;
        case (ins[31:26])
            OP_ANDI_LO: r = a & {16'h0000, ins[15:0]};
            OP_ANDI_HI: r = a & {ins[15:0], 16'h0000};
            default: begin
                upd = ins[0];
                r = (ins[10:1] == XO_ANDC) ? a & ~gm[ins[15:11]] : a & gm[ins[15:11]];
            end
        endcase
        gm[ins[20:16]] = r;
        if (upd) cr = {r[31], !r[31] && r != 32'h00000000, r == 32'h00000000, xer[31]};
        axi_host_i.wr(OFF_INSTR, ins, rr);
        rchk({1'b1, ins[20:16], 2'b00}, r, RESP_OKAY);
        chk({28'h0, negative_flag, positive_flag, zero_flag, so_copy}, {28'h0, cr}, "flags");
        rchk(OFF_XER, xer, RESP_OKAY);
    endtask
    logic [DATA_W-1:0] ops [10] = '{
        32'h7C863838, 32'h7C863839, 32'h7D262879, 32'h7D264878, 32'h70865730,
        32'h70860000, 32'h74E65730, 32'h7486FFFF, 32'h7C842879, 32'h7C863838};
    initial begin
        reset = 1'b1;
        s_axi_wstrb = 4'hF;
        err_total = 0;
        n_checks = 0;
        cyc = 0;
        cr = 4'h0;
        xer = 32'h00000000;
        repeat (16) @(posedge sys_clk);
        reset <= 1'b0;
        rchk(OFF_CR, 32'h00000000, RESP_OKAY);
        rchk(OFF_XER, 32'h00000000, RESP_OKAY);
        rchk(8'h80, 32'h00000000, RESP_OKAY);
        wgpr(5'h04, 32'hFFF25730);
        wgpr(5'h05, 32'h76767676);
        wgpr(5'h07, 32'h7B4192C0);
        wgpr(5'h09, 32'hB0043000);
        // Words: and, and., andc., andc, andi lo, andi lo zero, andi hi, andi hi neg, andc. in place, and
        for (int i = 0; i < 10; i++) begin
            if (i == 4) begin
                xer = 32'h80000000;
                axi_host_i.wr(OFF_XER, xer, rr);
            end
            op(ops[i]);
        end
        // A recorded non-AND word must leave the target, the flags and the exception register alone.
        axi_host_i.wr(OFF_INSTR, 32'h7CC63379, rr);
        chk({30'h0, rr}, {30'h0, RESP_OKAY}, "issue resp");
        rchk(8'h98, gm[6], RESP_OKAY);
        rchk(OFF_XER, xer, RESP_OKAY);
        rchk(OFF_STATUS, 32'h00000B01, RESP_OKAY);
        axi_host_i.wr(OFF_STATUS, 32'hFFFFFFFF, rr);
        chk({30'h0, rr}, {30'h0, RESP_OKAY}, "status write");
        rchk(OFF_STATUS, 32'h00000B01, RESP_OKAY);
        rchk(OFF_CR, {28'h0, cr}, RESP_OKAY);
        axi_host_i.wr(8'h10, 32'h00000001, rr);
        chk({30'h0, rr}, {30'h0, RESP_SLVERR}, "unmapped write");
        rchk(8'h7C, 32'h00000000, RESP_SLVERR);
        end_sim();
    end
endmodule
